// File: indoor_units_model.sv
// Behavioural model of the indoor unit controllers on the command link.
// Assumes one-cycle command pulses; dropCmd makes every unit ignore a command.
`timescale 1ns/100ps

module indoor_units_model
  import service_panel_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    cmdValid,
  input  wire service_panel_pkg::cmd_t cmdCode,
  input  wire logic                    cmdAll,
  input  wire logic [6:0]              cmdAddr,
  input  wire logic                    dropCmd,
  output      logic [63:0]             unitRun,
  output      logic [63:0]             unitTest
);
  logic [63:0] pick;

  // Units hit by a command; address 0 without cmdAll shifts past bit 63 and hits no unit
  assign pick = cmdAll ? '1 : (64'h1 << (cmdAddr - 7'h01));

  // Each unit runs on its own remote settings, so no settings travel here
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      unitRun <= '0;
      unitTest <= '0;
    end
    else if (cmdValid && !dropCmd)
    begin
      case (cmdCode)
        CMD_START:     unitRun <= unitRun | pick;
        CMD_STOP:      unitRun <= unitRun & ~pick;
        CMD_UNIT_TEST: unitTest <= unitTest | pick;
        CMD_TEST_END:  unitTest <= unitTest & ~pick;
        CMD_NONE:      unitTest <= unitTest;
        default:       unitTest <= '1;
      endcase
    end
  end
endmodule : indoor_units_model

// File: service_panel_pkg.sv
// Shared constants and types for the service start/stop panel.
// Assumes a 100 MHz system clock; all cycle counts derive from it.
package service_panel_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int    CLOCK_HZ          = 100_000_000;
  localparam int    DEBOUNCE_MS       = 10;
  localparam int    HOLD_SHORT_MS     = 2000;
  localparam int    HOLD_LONG_MS      = 10000;
  localparam int    ACK_SHOW_MS       = 5000;
  localparam int    TEST_RUN_MIN      = 60;
  localparam int    DEBOUNCE_CYCLES   = DEBOUNCE_MS * (CLOCK_HZ / 1000);
  localparam int    HOLD_SHORT_CYCLES = HOLD_SHORT_MS * (CLOCK_HZ / 1000);
  localparam int    HOLD_LONG_CYCLES  = HOLD_LONG_MS * (CLOCK_HZ / 1000);
  localparam int    ACK_SHOW_CYCLES   = ACK_SHOW_MS * (CLOCK_HZ / 1000);
  localparam longint TEST_RUN_CYCLES  = longint'(TEST_RUN_MIN) * 60 * longint'(CLOCK_HZ);

  // ==========================================================================
  // Selector positions
  // ==========================================================================
  localparam logic [4:0] SEL_SERVICE    = 5'h02;
  localparam logic [4:0] SEL_COOL       = 5'h05;
  localparam logic [4:0] SEL_HEAT       = 5'h06;
  localparam logic [4:0] SEL_BATCH      = 5'h07;
  localparam logic [4:0] SEL_ONE        = 5'h01;
  localparam logic [4:0] SEL_INDIVIDUAL = 5'h10;
  localparam logic [6:0] UNIT_ADDR_MAX  = 7'h40;

  // ==========================================================================
  // Register port map
  // ==========================================================================
  localparam logic [7:0] REG_CONTROL    = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam int         CTRL_ENABLE    = 0;
  localparam logic       CTRL_RESET     = 1'b1;
  localparam int         STAT_COLL_TEST = 0;
  localparam int         STAT_UNIT_TEST = 1;
  localparam int         STAT_ACK       = 2;
  localparam int         STAT_REFUSED   = 3;
  localparam int         STAT_LAST_LSB  = 8;
  localparam int         STAT_ADDR_LSB  = 16;

  // ==========================================================================
  // Display glyphs, two per section, high nibble is the left digit
  // ==========================================================================
  localparam logic [3:0] GLYPH_C     = 4'ha;
  localparam logic [3:0] GLYPH_H     = 4'hb;
  localparam logic [3:0] GLYPH_DASH  = 4'hc;
  localparam logic [3:0] GLYPH_F     = 4'hd;
  localparam logic [3:0] GLYPH_BLANK = 4'hf;

  // ==========================================================================
  // Commands and selector modes
  // ==========================================================================
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_START,
    CMD_STOP,
    CMD_COOL_TEST,
    CMD_HEAT_TEST,
    CMD_UNIT_TEST,
    CMD_TEST_END
  } cmd_t;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_COOL,
    MODE_HEAT,
    MODE_BATCH,
    MODE_UNIT
  } mode_t;

endpackage : service_panel_pkg

// File: service_start_stop_panel.sv
// Service command interpreter: selectors and keys in, one-shot indoor unit
// commands and two display sections out. Assumes switch pins are asynchronous
// and that error halt and follower map come from logic on the same clock.
`timescale 1ns/100ps

module service_start_stop_panel
  import service_panel_pkg::*;
#(
  parameter int     DEBOUNCE = DEBOUNCE_CYCLES,
  parameter int     HOLD_SHORT = HOLD_SHORT_CYCLES,
  parameter int     HOLD_LONG = HOLD_LONG_CYCLES,
  parameter int     ACK_SHOW = ACK_SHOW_CYCLES,
  parameter longint TEST_RUN = TEST_RUN_CYCLES
) (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic [4:0]                   functionSelectorFirst,
  input  wire logic [4:0]                   functionSelectorSecond,
  input  wire logic [4:0]                   functionSelectorThird,
  input  wire logic                         onCommandKey,
  input  wire logic                         offCommandKey,
  input  wire logic                         errorHalt,
  input  wire logic [63:0]                  followerMap,
  input  wire logic [7:0]                   regAddr,
  input  wire logic [31:0]                  regWdata,
  input  wire logic                         regWrite,
  input  wire logic                         regRead,
  output      logic [31:0]                  regRdata,
  output      logic                         cmdValid,
  output      service_panel_pkg::cmd_t      cmdCode,
  output      logic                         cmdAll,
  output      logic [6:0]                   cmdAddr,
  output      logic [7:0]                   displayA,
  output      logic [7:0]                   displayB
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [4:0]  selFirstMeta;
    logic [4:0]  selFirst;
    logic [4:0]  selSecondMeta;
    logic [4:0]  selSecond;
    logic [4:0]  selThirdMeta;
    logic [4:0]  selThird;
    logic        onMeta;
    logic        onSync;
    logic        offMeta;
    logic        offSync;
    logic        onKey;
    logic        offKey;
    logic [31:0] onDeb;
    logic [31:0] offDeb;
    logic [31:0] hold;
    logic        holdOn;
    logic        holdOff;
    logic        fired;
    logic        cmdValid;
    cmd_t        cmdCode;
    logic        cmdAll;
    logic [6:0]  cmdAddr;
    logic [7:0]  dispA;
    logic [7:0]  dispB;
    logic [31:0] ack;
    logic [7:0]  ackB;
    logic [7:0]  ackA;
    logic        collTest;
    logic        unitTest;
    logic [6:0]  testAddr;
    logic [39:0] collTimer;
    logic [39:0] unitTimer;
    logic        collEndPend;
    logic        unitEndPend;
    logic        enable;
    logic        refused;
    cmd_t        lastCmd;
    logic [31:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;

  mode_t      mode;
  logic [8:0] unitNum;
  logic       addrValid;
  logic [6:0] addr;
  logic       isFollower;
  logic       released;
  logic [7:0] addrDigits;
  logic       actOk;
  logic       doOn;
  logic       doOff;
  logic       doUnitTest;
  logic [31:0] status;

  // ==========================================================================
  // Selector decode
  // ==========================================================================
  // Address is second selector as group of 16 plus third selector
  assign unitNum    = {s.selSecond, 4'h0} - 9'h010 + {4'h0, s.selThird};
  assign addrValid  = (s.selSecond != 5'h00) && (s.selThird != 5'h00)
                      && (unitNum != 9'h000) && (unitNum <= {2'b00, UNIT_ADDR_MAX});
  assign addr       = unitNum[6:0];
  assign isFollower = addrValid && followerMap[6'(addr - 7'h01)];
  assign released   = (s.selFirst == SEL_ONE) && (s.selSecond == SEL_ONE) && (s.selThird == SEL_ONE);
  assign addrDigits = {4'(addr / 7'h0a), 4'(addr % 7'h0a)};
  // Halted system or disabled panel swallows the press
  assign actOk      = s.enable && !errorHalt;

  always_comb
  begin
    mode = MODE_NONE;
    if (s.selFirst == SEL_SERVICE && s.selThird == SEL_ONE)
    begin
      case (s.selSecond)
        SEL_COOL:  mode = MODE_COOL;
        SEL_HEAT:  mode = MODE_HEAT;
        SEL_BATCH: mode = MODE_BATCH;
        default:   mode = MODE_NONE;
      endcase
    end
    else if (s.selFirst == SEL_INDIVIDUAL && addrValid)
    begin
      mode = MODE_UNIT;
    end
  end

  // Status word seen by software
  always_comb
  begin
    status = 32'h0000_0000;
    status[STAT_COLL_TEST] = s.collTest;
    status[STAT_UNIT_TEST] = s.unitTest;
    status[STAT_ACK] = (s.ack != 32'h0000_0000);
    status[STAT_REFUSED] = s.refused;
    status[STAT_LAST_LSB +: 3] = s.lastCmd;
    status[STAT_ADDR_LSB +: 7] = s.testAddr;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    next_s = s;
    doOn = 1'b0;
    doOff = 1'b0;
    doUnitTest = 1'b0;
    next_s.cmdValid = 1'b0;

    // Two flops on every selector and key pin before any logic reads it
    next_s.selFirstMeta = functionSelectorFirst;
    next_s.selFirst = s.selFirstMeta;
    next_s.selSecondMeta = functionSelectorSecond;
    next_s.selSecond = s.selSecondMeta;
    next_s.selThirdMeta = functionSelectorThird;
    next_s.selThird = s.selThirdMeta;
    next_s.onMeta = onCommandKey;
    next_s.onSync = s.onMeta;
    next_s.offMeta = offCommandKey;
    next_s.offSync = s.offMeta;

    // Debounce: level must stay changed for the whole window
    if (s.onSync == s.onKey)
      next_s.onDeb = 32'h0000_0000;
    else if (s.onDeb >= 32'(DEBOUNCE - 1))
    begin
      next_s.onKey = s.onSync;
      next_s.onDeb = 32'h0000_0000;
    end
    else
      next_s.onDeb = s.onDeb + 32'h0000_0001;
    if (s.offSync == s.offKey)
      next_s.offDeb = 32'h0000_0000;
    else if (s.offDeb >= 32'(DEBOUNCE - 1))
    begin
      next_s.offKey = s.offSync;
      next_s.offDeb = 32'h0000_0000;
    end
    else
      next_s.offDeb = s.offDeb + 32'h0000_0001;

    // Hold timing; only one key is timed at a time
    if (!s.holdOn && !s.holdOff)
    begin
      next_s.hold = 32'h0000_0000;
      next_s.fired = 1'b0;
      next_s.holdOn = s.onKey && !s.offKey;
      next_s.holdOff = s.offKey && !s.onKey;
    end
    else if (s.holdOn)
    begin
      if (s.onKey)
      begin
        if (s.hold < 32'(HOLD_LONG))
          next_s.hold = s.hold + 32'h0000_0001;
        if (!s.fired && mode != MODE_UNIT && s.hold == 32'(HOLD_SHORT - 1))
        begin
          doOn = 1'b1;
          next_s.fired = 1'b1;
        end
        if (!s.fired && mode == MODE_UNIT && s.hold == 32'(HOLD_LONG - 1))
        begin
          doUnitTest = 1'b1;
          next_s.fired = 1'b1;
        end
      end
      else
      begin
        // Unit start must wait for release to tell it from a test hold
        if (!s.fired && mode == MODE_UNIT && s.hold >= 32'(HOLD_SHORT))
          doOn = 1'b1;
        next_s.holdOn = 1'b0;
      end
    end
    else
    begin
      if (s.offKey)
      begin
        if (s.hold < 32'(HOLD_SHORT))
          next_s.hold = s.hold + 32'h0000_0001;
        if (!s.fired && s.hold == 32'(HOLD_SHORT - 1))
        begin
          doOff = 1'b1;
          next_s.fired = 1'b1;
        end
      end
      else
        next_s.holdOff = 1'b0;
    end

    // Test run timers, end command queued until the link is free
    if (s.collTest)
    begin
      if (s.collTimer <= 40'h00_0000_0001)
      begin
        next_s.collTest = 1'b0;
        next_s.collEndPend = 1'b1;
      end
      else
        next_s.collTimer = s.collTimer - 40'h00_0000_0001;
    end
    if (s.unitTest)
    begin
      if (s.unitTimer <= 40'h00_0000_0001)
      begin
        next_s.unitTest = 1'b0;
        next_s.unitEndPend = 1'b1;
      end
      else
        next_s.unitTimer = s.unitTimer - 40'h00_0000_0001;
    end

    // Acknowledge display countdown; selectors back to 1 drop it at once
    if (released)
      next_s.ack = 32'h0000_0000;
    else if (s.ack != 32'h0000_0000)
      next_s.ack = s.ack - 32'h0000_0001;

    // One command per cycle; a key action wins over a pending test end
    if ((doOn || doOff || doUnitTest) && actOk && mode != MODE_NONE)
    begin
      next_s.refused = 1'b0;
      next_s.cmdAll = (mode != MODE_UNIT);
      next_s.cmdAddr = (mode == MODE_UNIT) ? addr : 7'h00;
      if (mode == MODE_UNIT && isFollower)
      begin
        next_s.refused = 1'b1;
        next_s.ackA = addrDigits;
        next_s.ackB = {GLYPH_DASH, GLYPH_DASH};
        next_s.ack = 32'(ACK_SHOW);
      end
      else
      begin
        next_s.cmdValid = 1'b1;
        next_s.ack = 32'(ACK_SHOW);
        next_s.ackA = (mode == MODE_UNIT) ? addrDigits : {GLYPH_C, GLYPH_H};
        case (mode)
          MODE_COOL:
          begin
            next_s.cmdCode = doOn ? CMD_COOL_TEST : CMD_NONE;
            next_s.cmdValid = doOn;
            next_s.ack = 32'h0000_0000;
            next_s.collTest = doOn ? 1'b1 : s.collTest;
            next_s.collTimer = doOn ? 40'(TEST_RUN) : s.collTimer;
          end
          MODE_HEAT:
          begin
            next_s.cmdCode = doOn ? CMD_HEAT_TEST : CMD_NONE;
            next_s.cmdValid = doOn;
            next_s.ack = 32'h0000_0000;
            next_s.collTest = doOn ? 1'b1 : s.collTest;
            next_s.collTimer = doOn ? 40'(TEST_RUN) : s.collTimer;
          end
          MODE_BATCH:
          begin
            // Plain start: units keep their own remote settings
            next_s.cmdCode = doOn ? CMD_START : CMD_STOP;
            next_s.ackB = doOn ? 8'h11 : 8'h00;
          end
          MODE_UNIT:
          begin
            if (doUnitTest)
            begin
              next_s.cmdCode = CMD_UNIT_TEST;
              next_s.ackB = {GLYPH_F, GLYPH_F};
              next_s.unitTest = 1'b1;
              next_s.testAddr = addr;
              next_s.unitTimer = 40'(TEST_RUN);
            end
            else
            begin
              next_s.cmdCode = doOn ? CMD_START : CMD_STOP;
              next_s.ackB = doOn ? 8'h11 : 8'h00;
            end
          end
          default:
            next_s.cmdValid = 1'b0;
        endcase
      end
      if (next_s.cmdValid)
        next_s.lastCmd = next_s.cmdCode;
    end
    else if (s.collEndPend)
    begin
      next_s.collEndPend = 1'b0;
      next_s.cmdValid = 1'b1;
      next_s.cmdCode = CMD_TEST_END;
      next_s.cmdAll = 1'b1;
      next_s.cmdAddr = 7'h00;
      next_s.lastCmd = CMD_TEST_END;
    end
    else if (s.unitEndPend)
    begin
      next_s.unitEndPend = 1'b0;
      next_s.cmdValid = 1'b1;
      next_s.cmdCode = CMD_TEST_END;
      next_s.cmdAll = 1'b0;
      next_s.cmdAddr = s.testAddr;
      next_s.lastCmd = CMD_TEST_END;
    end

    // Display: acknowledge overrides the mode code on both sections A and B
    case (mode)
      MODE_COOL:
      begin
        next_s.dispA = {GLYPH_C, GLYPH_BLANK};
        next_s.dispB = {GLYPH_DASH, GLYPH_C};
      end
      MODE_HEAT:
      begin
        next_s.dispA = {GLYPH_H, GLYPH_BLANK};
        next_s.dispB = {GLYPH_DASH, GLYPH_H};
      end
      MODE_BATCH:
      begin
        next_s.dispA = {GLYPH_C, GLYPH_H};
        next_s.dispB = {GLYPH_BLANK, GLYPH_BLANK};
      end
      MODE_UNIT:
      begin
        next_s.dispA = addrDigits;
        next_s.dispB = {GLYPH_BLANK, GLYPH_BLANK};
      end
      default:
      begin
        next_s.dispA = {GLYPH_BLANK, GLYPH_BLANK};
        next_s.dispB = {GLYPH_BLANK, GLYPH_BLANK};
      end
    endcase
    if (next_s.ack != 32'h0000_0000)
    begin
      next_s.dispA = next_s.ackA;
      next_s.dispB = next_s.ackB;
    end

    // Register port: write takes effect next edge, read data next cycle
    if (regWrite && regAddr == REG_CONTROL)
      next_s.enable = regWdata[CTRL_ENABLE];
    next_s.rdata = 32'h0000_0000;
    if (regRead)
    begin
      case (regAddr)
        REG_CONTROL: next_s.rdata = {31'h0000_0000, s.enable};
        REG_STATUS:  next_s.rdata = status;
        default:     next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.enable <= CTRL_RESET;
      s.cmdCode <= CMD_NONE;
      s.lastCmd <= CMD_NONE;
      s.selFirstMeta <= SEL_ONE;
      s.selFirst <= SEL_ONE;
      s.selSecondMeta <= SEL_ONE;
      s.selSecond <= SEL_ONE;
      s.selThirdMeta <= SEL_ONE;
      s.selThird <= SEL_ONE;
      s.dispA <= {GLYPH_BLANK, GLYPH_BLANK};
      s.dispB <= {GLYPH_BLANK, GLYPH_BLANK};
    end
    else
      s <= next_s;
  end

  // Outputs come straight from flops
  assign regRdata = s.rdata;
  assign cmdValid = s.cmdValid;
  assign cmdCode  = s.cmdCode;
  assign cmdAll   = s.cmdAll;
  assign cmdAddr  = s.cmdAddr;
  assign displayA = s.dispA;
  assign displayB = s.dispB;

endmodule : service_start_stop_panel

// File: service_start_stop_panel_assertions.sv
// Concurrent checks on the service panel's command and display outputs.
// Assumes the bench holds selectors steady for several cycles around a press.
`timescale 1ns/100ps

module service_start_stop_panel_assertions
  import service_panel_pkg::*;
#(
  parameter int ACK_SHOW = 30
) (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire logic [4:0]              functionSelectorSecond,
  input wire logic                    errorHalt,
  input wire logic                    regRead,
  input wire logic [31:0]             regRdata,
  input wire logic                    cmdValid,
  input wire service_panel_pkg::cmd_t cmdCode,
  input wire logic                    cmdAll,
  input wire logic [6:0]              cmdAddr,
  input wire logic [7:0]              displayB
);
  // Window for the acknowledge to fall back, a little slack either side
  localparam int ACK_LO = ACK_SHOW - 2;
  localparam int ACK_HI = ACK_SHOW + 2;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Command pulses
  // ==========================================================================
  property p_one_shot;
    cmdValid |=> !cmdValid;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("command pulse longer than one cycle");
  property p_halt;
    (cmdValid && cmdCode != CMD_TEST_END) |-> !$past(errorHalt);
  endproperty
  a_halt: assert property (p_halt)
    else $error("command issued during error halt");
  property p_all_addr;
    (cmdValid && cmdAll) |-> cmdAddr == 7'h00;
  endproperty
  a_all_addr: assert property (p_all_addr)
    else $error("collective command carries an address");
  property p_unit_addr;
    (cmdValid && !cmdAll) |-> cmdAddr inside {[7'h01:UNIT_ADDR_MAX]};
  endproperty
  a_unit_addr: assert property (p_unit_addr)
    else $error("individual command address out of range");
  // Mode tests only come from the matching selector setting
  property p_mode_test;
    (cmdValid && cmdCode inside {CMD_COOL_TEST, CMD_HEAT_TEST}) |-> cmdAll &&
      $past(functionSelectorSecond, 4) == ((cmdCode == CMD_COOL_TEST) ? SEL_COOL : SEL_HEAT);
  endproperty
  a_mode_test: assert property (p_mode_test)
    else $error("mode test from wrong selector setting");

  // ==========================================================================
  // Acknowledge display
  // ==========================================================================
  property p_start_ack;
    (cmdValid && cmdCode == CMD_START) |-> (displayB == 8'h11) [*8];
  endproperty
  a_start_ack: assert property (p_start_ack)
    else $error("start acknowledge not shown");
  property p_stop_ack;
    (cmdValid && cmdCode == CMD_STOP) |-> (displayB == 8'h00) [*8];
  endproperty
  a_stop_ack: assert property (p_stop_ack)
    else $error("stop acknowledge not shown");
  property p_test_ack;
    (cmdValid && cmdCode == CMD_UNIT_TEST) |-> !cmdAll && displayB == 8'hdd;
  endproperty
  a_test_ack: assert property (p_test_ack)
    else $error("unit test acknowledge not shown");
  property p_ack_end;
    (cmdValid && cmdCode == CMD_START) |-> ##[ACK_LO:ACK_HI] displayB == 8'hff;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("acknowledge did not time out");
  property p_rdata_idle;
    !$past(regRead) |-> regRdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");
endmodule : service_start_stop_panel_assertions

bind service_start_stop_panel service_start_stop_panel_assertions #(.ACK_SHOW(ACK_SHOW)) chk (
  .clock, .rst_n, .functionSelectorSecond, .errorHalt, .regRead, .regRdata,
  .cmdValid, .cmdCode, .cmdAll, .cmdAddr, .displayB
);

// File: test_service_start_stop_panel.sv
// Self-checking bench: selectors, keys, halt and registers against a queue model.
// Assumes shortened timing and the indoor unit model on the command outputs.
`timescale 1ns/100ps

module test_service_start_stop_panel;
  import service_panel_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int TR = 200;
  logic        clock = 1'b0, rst_n = 1'b0, onCommandKey = 1'b0, offCommandKey = 1'b0;
  logic        errorHalt = 1'b0, regWrite = 1'b0, regRead = 1'b0, dropCmd = 1'b0;
  logic [4:0]  functionSelectorFirst = 5'h01, functionSelectorSecond = 5'h01;
  logic [4:0]  functionSelectorThird = 5'h01;
  logic [63:0] followerMap = '0, unitRun, unitTest, expRun = '0;
  logic [7:0]  regAddr = '0, displayA, displayB;
  logic [31:0] regWdata = '0, regRdata, rd;
  logic [6:0]  cmdAddr;
  logic        cmdValid, cmdAll;
  cmd_t        cmdCode;
  logic [10:0] gotQ[$], expQ[$];
  int          miscompares = 0, compares = 0, a;
  int          addrList[3];

  always #5 clock = ~clock;

  service_start_stop_panel #(.DEBOUNCE(4), .HOLD_SHORT(20), .HOLD_LONG(60), .ACK_SHOW(30), .TEST_RUN(TR)) uut (
    .clock, .rst_n, .functionSelectorFirst, .functionSelectorSecond, .functionSelectorThird,
    .onCommandKey, .offCommandKey, .errorHalt, .followerMap, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .cmdValid, .cmdCode, .cmdAll, .cmdAddr, .displayA, .displayB
  );
  indoor_units_model units (
    .clock, .rst_n, .cmdValid, .cmdCode, .cmdAll, .cmdAddr, .dropCmd, .unitRun, .unitTest
  );

  // Record every command pulse as issued
  always @(posedge clock)
  begin
    if (cmdValid === 1'b1)
      gotQ.push_back({cmdCode, cmdAll, cmdAddr});
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic close_out;
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic wr_reg(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= addr;
    regWdata <= data;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] addr);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= addr;
    @(posedge clock);
    regRead <= 1'b0;
    #1 rd = regRdata;
  endtask : rd_reg

  task automatic set_sel(input int s1, input int s2, input int s3);
    @(posedge clock);
    functionSelectorFirst <= 5'(s1);
    functionSelectorSecond <= 5'(s2);
    functionSelectorThird <= 5'(s3);
    cyc(6);
  endtask : set_sel

  // Gap of 40 lets an acknowledge run out before the next press
  task automatic press(input logic [1:0] keys, input int hold, input int gap);
    @(posedge clock);
    onCommandKey <= keys[0];
    offCommandKey <= keys[1];
    cyc(hold);
    onCommandKey <= 1'b0;
    offCommandKey <= 1'b0;
    cyc(gap);
  endtask : press

  // Queue model: expected command and resulting unit state
  task automatic exp_cmd(input cmd_t code, input logic all, input int addr);
    logic [63:0] pick;
    pick = all ? '1 : 64'h1 << (addr - 1);
    expQ.push_back({code, all, 7'(addr)});
    if (!dropCmd && code == CMD_START)
      expRun = expRun | pick;
    if (!dropCmd && code == CMD_STOP)
      expRun = expRun & ~pick;
  endtask : exp_cmd

  task automatic check_cmds;
    check("command count", expQ.size(), gotQ.size());
    while (expQ.size() > 0 && gotQ.size() > 0)
      check("command", expQ.pop_front(), gotQ.pop_front());
    expQ.delete();
    gotQ.delete();
    check("units running", expRun, unitRun);
  endtask : check_cmds

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    void'($urandom(91055));
    addrList = '{1, 64, $urandom_range(63, 2)};
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    check("displayA", 8'hff, displayA);
    check("displayB", 8'hff, displayB);
    rd_reg(REG_STATUS);
    check("status", 32'h0, rd);
    wr_reg(8'h0c, 32'h0);
    rd_reg(8'h0c);
    check("unmapped", 32'h0, rd);
    rd_reg(REG_CONTROL);
    check("control", 32'h1, rd);
    for (int i = 0; i < 2; i++)
    begin
      set_sel(2, i ? 6 : 5, 1);
      check("displayA", i ? 8'hbf : 8'haf, displayA);
      check("displayB", i ? 8'hcb : 8'hca, displayB);
      press(2'b01, 80, 40);
      press(2'b10, 35, 40);
      cyc(TR);
      exp_cmd(i ? CMD_HEAT_TEST : CMD_COOL_TEST, 1'b1, 0);
      exp_cmd(CMD_TEST_END, 1'b1, 0);
      check_cmds();
    end
    // Batch: short press, both keys, start, stop nobody obeys, stop again
    set_sel(2, 7, 1);
    check("displayA", 8'hab, displayA);
    press(2'b01, 20, 40);
    press(2'b11, 35, 40);
    press(2'b01, 35, 40);
    exp_cmd(CMD_START, 1'b1, 0);
    dropCmd <= 1'b1;
    press(2'b10, 35, 40);
    exp_cmd(CMD_STOP, 1'b1, 0);
    dropCmd <= 1'b0;
    check_cmds();
    press(2'b10, 35, 40);
    exp_cmd(CMD_STOP, 1'b1, 0);
    check_cmds();
    // Error halt and disabled keys each refuse a start press
    errorHalt <= 1'b1;
    press(2'b01, 35, 40);
    errorHalt <= 1'b0;
    wr_reg(REG_CONTROL, 32'h0);
    press(2'b01, 35, 40);
    wr_reg(REG_CONTROL, 32'h1);
    check_cmds();
    foreach (addrList[k])
    begin
      a = addrList[k];
      set_sel(16, (a - 1) / 16 + 1, (a - 1) % 16 + 1);
      check("displayA", {4'(a / 10), 4'(a % 10)}, displayA);
      press(2'b01, 35, 40);
      exp_cmd(CMD_START, 1'b0, a);
      check_cmds();
      press(2'b10, 35, 40);
      press(2'b01, 80, 40);
      cyc(TR);
      exp_cmd(CMD_STOP, 1'b0, a);
      exp_cmd(CMD_UNIT_TEST, 1'b0, a);
      exp_cmd(CMD_TEST_END, 1'b0, a);
      check_cmds();
    end
    followerMap[a - 1] <= 1'b1;
    press(2'b01, 35, 12);
    check("displayB", 8'hcc, displayB);
    rd_reg(REG_STATUS);
    check("status", 32'h0000_060c | (32'(a) << 16), rd);
    cyc(40);
    check_cmds();
    followerMap <= '0;
    set_sel(1, 1, 1);
    close_out();
  end

  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    cyc(20000);
    miscompares++;
    close_out();
  end
endmodule : test_service_start_stop_panel
